// file: hw/bal_pkg.sv
// Package with the operation codes, states and reset values of the byte datapath.
package bal_pkg;

  // Operations carried out by the datapath.
  typedef enum logic [2:0] {
    and_literal_op,
    add_literal_op,
    and_register_op,
    add_register_op,
    add_register_with_carry_op,
    arith_shift_right_op,
    bit_clear_op,
    pointer_add_literal_op
  } bal_op_e;

  // Sequencer states: a normal cycle, or the extra cycle of an indirect access.
  typedef enum logic {
    bal_idle,
    bal_stall
  } bal_state_e;

  // Field widths and positions.
  localparam int DATA_W        = 8;
  localparam int PTR_W         = 16;
  localparam int FILE_ADDR_W   = 7;
  localparam int BIT_SEL_W     = 3;
  localparam int PTR_LIT_W     = 6;
  localparam int PTR_LIT_SIGN  = 5;
  localparam int NIBBLE_TOP    = 3;
  localparam int MSB_POS       = 7;

  // Destination select encodings.
  localparam logic DEST_ACCUM  = 1'b0;
  localparam logic DEST_FILE   = 1'b1;

  // Values after reset.
  localparam logic [7:0]  ACCUM_RST = 8'h00;
  localparam logic [15:0] PTR_RST   = 16'h0000;
  localparam logic [6:0]  ADDR_RST  = 7'h00;
  localparam logic        FLAG_RST  = 1'b0;
  localparam logic        READY_RST = 1'b1;

  // Instruction cycles of a normal operation and extra cycles of an indirect access.
  localparam int BASE_CYCLES   = 1;
  localparam int EXTRA_CYCLES  = 1;

endpackage

// file: hw/bal_adder8.sv
// Eight-bit adder with carry in, carry out of bit 7 and carry out of bit 3.
`timescale 1ns/1ns
module bal_adder8
(
  // Operands.
  input  wire logic [7:0] i_a,
  input  wire logic [7:0] i_b,
  input  wire logic       i_cin,
  // Results.
  output logic [7:0]      o_sum,
  output logic            o_carry,
  output logic            o_nibble_carry
);

  logic [8:0] full_sum;
  logic [4:0] low_sum;

  // Full sum gives the carry out of bit 7, the low nibble sum the carry out of bit 3.
  assign full_sum       = {1'b0, i_a} + {1'b0, i_b} + {8'h00, i_cin};
  assign low_sum        = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]} + {4'h0, i_cin};
  assign o_sum          = full_sum[7:0];
  assign o_carry        = full_sum[8];
  assign o_nibble_carry = low_sum[4];

endmodule

// file: hw/bal_ptr_adder.sv
// Adds a sign-extended six-bit literal to a sixteen-bit pointer with wrap-around.
`timescale 1ns/1ns
module bal_ptr_adder
(
  // Operands.
  input  wire logic [15:0] i_ptr,
  input  wire logic [5:0]  i_lit,
  // Result.
  output logic [15:0]      o_sum
);

  logic [15:0] lit_ext;

  // The literal sign bit fills the upper ten bits, so -32 to 31 is covered.
  assign lit_ext = {{10{i_lit[bal_pkg::PTR_LIT_SIGN]}}, i_lit};
  // The carry out of bit 15 is dropped, so the sum wraps modulo 65536.
  assign o_sum   = i_ptr + lit_ext;

endmodule

// file: hw/bal_core.sv
// Execution datapath for the byte arithmetic, logic, bit-clear and pointer-add operations.
`timescale 1ns/1ns
module bal_core
(
  // Clock and reset.
  input  wire logic                  i_core_clk,
  input  wire logic                  i_rst,
  // Operation request from the decoder.
  input  wire logic                  i_op_valid,
  input  wire bal_pkg::bal_op_e      i_op,
  input  wire logic [7:0]            i_literal,
  input  wire logic [6:0]            i_file_addr,
  input  wire logic [7:0]            i_file_rdata,
  input  wire logic                  i_dest_sel,
  input  wire logic [2:0]            i_bit_sel,
  input  wire logic                  i_ptr_sel,
  input  wire logic                  i_indirect_slow,
  // Handshake back to the decoder.
  output logic                       o_ready,
  output logic                       o_done,
  // Accumulator and status flags.
  output logic [7:0]                 o_accum,
  output logic                       o_carry,
  output logic                       o_nibble_overflow_bit,
  output logic                       o_zero,
  // Write port into data memory.
  output logic                       o_file_we,
  output logic [6:0]                 o_file_addr,
  output logic [7:0]                 o_file_wdata,
  // Indirect pointers.
  output logic [15:0]                o_indirect_pointer0,
  output logic [15:0]                o_indirect_pointer1
);

  // Whole state of the datapath.
  typedef struct packed {
    bal_pkg::bal_state_e fsm;
    logic                ready;
    logic                done;
    logic [7:0]          accum;
    logic                carry;
    logic                nibble;
    logic                zero;
    logic [15:0]         ptr0;
    logic [15:0]         ptr1;
    logic                file_we;
    logic [6:0]          file_addr;
    logic [7:0]          file_wdata;
    bal_pkg::bal_op_e    op;
    logic [7:0]          lit;
    logic [6:0]          addr;
    logic [7:0]          fdata;
    logic                dest;
    logic [2:0]          bit_sel;
    logic                ptr_sel;
  } bal_state_s;

  bal_state_s s_q;
  bal_state_s s_d;

  // Operands of the operation being executed this cycle.
  bal_pkg::bal_op_e x_op;
  logic [7:0]       x_lit;
  logic [6:0]       x_addr;
  logic [7:0]       x_fdata;
  logic             x_dest;
  logic [2:0]       x_bit_sel;
  logic             x_ptr_sel;
  logic             accept;
  logic             exec;

  // Adder inputs and outputs.
  logic [7:0]       add_b;
  logic             add_cin;
  logic [7:0]       add_sum;
  logic             add_carry;
  logic             add_nibble;
  logic [15:0]      ptr_in;
  logic [15:0]      ptr_sum;

  // True for the two byte operations whose second operand is the literal; pointer add is not included.
  function automatic logic uses_literal(input bal_pkg::bal_op_e op);
    uses_literal = (op == bal_pkg::and_literal_op) || (op == bal_pkg::add_literal_op);
  endfunction

  // True when an eight-bit result is all zeros.
  function automatic logic is_zero(input logic [7:0] value);
    is_zero = (value == 8'h00);
  endfunction

  // A request is taken whenever the datapath is ready.
  assign accept = s_q.ready && i_op_valid;

  // Operands come straight from the request, or from the latched copy after a stall.
  // The copy holds the file data seen at the taking edge, so a stall never reads memory again.
  always_comb
  begin
    if (s_q.fsm == bal_pkg::bal_stall)
    begin
      x_op      = s_q.op;
      x_lit     = s_q.lit;
      x_addr    = s_q.addr;
      x_fdata   = s_q.fdata;
      x_dest    = s_q.dest;
      x_bit_sel = s_q.bit_sel;
      x_ptr_sel = s_q.ptr_sel;
      exec      = 1'b1;
    end
    else
    begin
      x_op      = i_op;
      x_lit     = i_literal;
      x_addr    = i_file_addr;
      x_fdata   = i_file_rdata;
      x_dest    = i_dest_sel;
      x_bit_sel = i_bit_sel;
      x_ptr_sel = i_ptr_sel;
      exec      = accept && !i_indirect_slow;
    end
  end

  // Adder operand selection: literal or register, carry in only for add with carry.
  assign add_b   = uses_literal(x_op) ? x_lit : x_fdata;
  assign add_cin = (x_op == bal_pkg::add_register_with_carry_op) ? s_q.carry : 1'b0;
  assign ptr_in  = x_ptr_sel ? s_q.ptr1 : s_q.ptr0;

  // Shared byte adder for all byte additions.
  bal_adder8 u_adder8
  (
    .i_a            (s_q.accum),
    .i_b            (add_b),
    .i_cin          (add_cin),
    .o_sum          (add_sum),
    .o_carry        (add_carry),
    .o_nibble_carry (add_nibble)
  );

  // Pointer adder for the pointer-add operation.
  bal_ptr_adder u_ptr_adder
  (
    .i_ptr (ptr_in),
    .i_lit (x_lit[bal_pkg::PTR_LIT_W-1:0]),
    .o_sum (ptr_sum)
  );

  // Next-state logic: sequencing, result routing and flag updates.
  always_comb
  begin
    logic [7:0] result;
    logic       route;
    result     = 8'h00;
    route      = 1'b0;
    s_d        = s_q;
    s_d.done   = 1'b0;
    s_d.file_we = 1'b0;

    // A slow request is latched and executed one cycle later.
    if (s_q.fsm == bal_pkg::bal_idle && accept && i_indirect_slow)
    begin
      s_d.fsm     = bal_pkg::bal_stall;
      s_d.ready   = 1'b0;
      s_d.op      = i_op;
      s_d.lit     = i_literal;
      s_d.addr    = i_file_addr;
      s_d.fdata   = i_file_rdata;
      s_d.dest    = i_dest_sel;
      s_d.bit_sel = i_bit_sel;
      s_d.ptr_sel = i_ptr_sel;
    end

    // Execute now: flags that the operation does not name keep their value,
    // and any write pulse lasts exactly the one cycle in which done is high.
    if (exec)
    begin
      s_d.fsm   = bal_pkg::bal_idle;
      s_d.ready = 1'b1;
      s_d.done  = 1'b1;
      unique case (x_op)
        bal_pkg::and_literal_op:
        begin
          s_d.accum = s_q.accum & x_lit;
          s_d.zero  = is_zero(s_q.accum & x_lit);
        end
        bal_pkg::add_literal_op:
        begin
          s_d.accum  = add_sum;
          s_d.carry  = add_carry;
          s_d.nibble = add_nibble;
          s_d.zero   = is_zero(add_sum);
        end
        bal_pkg::and_register_op:
        begin
          result    = s_q.accum & x_fdata;
          route     = 1'b1;
          s_d.zero  = is_zero(result);
        end
        bal_pkg::add_register_op,
        bal_pkg::add_register_with_carry_op:
        begin
          result     = add_sum;
          route      = 1'b1;
          s_d.carry  = add_carry;
          s_d.nibble = add_nibble;
          s_d.zero   = is_zero(add_sum);
        end
        bal_pkg::arith_shift_right_op:
        begin
          result    = {x_fdata[bal_pkg::MSB_POS], x_fdata[7:1]};
          route     = 1'b1;
          s_d.carry = x_fdata[0];
          s_d.zero  = is_zero({x_fdata[bal_pkg::MSB_POS], x_fdata[7:1]});
        end
        bal_pkg::bit_clear_op:
        begin
          // Only the chosen bit is cleared; the result always goes back to the register.
          s_d.file_we    = 1'b1;
          s_d.file_addr  = x_addr;
          s_d.file_wdata = x_fdata & ~(8'h01 << x_bit_sel);
        end
        bal_pkg::pointer_add_literal_op:
        begin
          // The pointer pair that is not selected is left as it is.
          if (x_ptr_sel)
          begin
            s_d.ptr1 = ptr_sum;
          end
          else
          begin
            s_d.ptr0 = ptr_sum;
          end
        end
      endcase

      // Register results follow the destination select.
      // Bit clear and the literal operations leave route low and never pass through here.
      if (route)
      begin
        if (x_dest == bal_pkg::DEST_FILE)
        begin
          s_d.file_we    = 1'b1;
          s_d.file_addr  = x_addr;
          s_d.file_wdata = result;
        end
        else
        begin
          s_d.accum = result;
        end
      end
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      // Done and write enable start low, so no stray write pulse follows reset.
      s_q            <= '0;
      s_q.fsm        <= bal_pkg::bal_idle;
      s_q.ready      <= bal_pkg::READY_RST;
      s_q.accum      <= bal_pkg::ACCUM_RST;
      s_q.carry      <= bal_pkg::FLAG_RST;
      s_q.nibble     <= bal_pkg::FLAG_RST;
      s_q.zero       <= bal_pkg::FLAG_RST;
      s_q.ptr0       <= bal_pkg::PTR_RST;
      s_q.ptr1       <= bal_pkg::PTR_RST;
      s_q.file_addr  <= bal_pkg::ADDR_RST;
      s_q.file_wdata <= bal_pkg::ACCUM_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Outputs come straight from the state register.
  assign o_ready               = s_q.ready;
  assign o_done                = s_q.done;
  assign o_accum               = s_q.accum;
  assign o_carry               = s_q.carry;
  assign o_nibble_overflow_bit = s_q.nibble;
  assign o_zero                = s_q.zero;
  assign o_file_we             = s_q.file_we;
  assign o_file_addr           = s_q.file_addr;
  assign o_file_wdata          = s_q.file_wdata;
  assign o_indirect_pointer0   = s_q.ptr0;
  assign o_indirect_pointer1   = s_q.ptr1;

endmodule

// file: bench/bal_core_monitor.sv
// Checker that watches the datapath ports for timing, routing and flag relations.
`timescale 1ns/1ns
module bal_core_monitor
(
  // Clock and reset.
  input wire logic             i_core_clk,
  input wire logic             i_rst,
  // Request from the decoder.
  input wire logic             i_op_valid,
  input wire bal_pkg::bal_op_e i_op,
  input wire logic [7:0]       i_literal,
  input wire logic [6:0]       i_file_addr,
  input wire logic [7:0]       i_file_rdata,
  input wire logic             i_dest_sel,
  input wire logic [2:0]       i_bit_sel,
  input wire logic             i_indirect_slow,
  // Results of the datapath.
  input wire logic             o_ready,
  input wire logic             o_done,
  input wire logic [7:0]       o_accum,
  input wire logic             o_carry,
  input wire logic             o_nibble_overflow_bit,
  input wire logic             o_zero,
  input wire logic             o_file_we,
  input wire logic [6:0]       o_file_addr,
  input wire logic [7:0]       o_file_wdata
);
  // A taken request, a fast one, and a fast one that routes by the select bit.
  wire take = i_op_valid && o_ready;
  wire fast = take && !i_indirect_slow;
  wire fop  = fast && i_op inside {bal_pkg::and_register_op, bal_pkg::add_register_op,
    bal_pkg::add_register_with_carry_op, bal_pkg::arith_shift_right_op};

  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  // Completion timing of fast and stalled requests.
  property p_fast; fast |=> o_done && o_ready; endproperty
  a_fast: assert property (p_fast) else $error("fast request not done next cycle");
  property p_slow; take && i_indirect_slow |=> !o_ready && !o_done ##1 o_done && o_ready; endproperty
  a_slow: assert property (p_slow) else $error("slow request not done after one stall");
  // Literal operations on the accumulator.
  property p_and_lit; fast && i_op == bal_pkg::and_literal_op |=> o_accum == $past(o_accum & i_literal)
    && o_zero == (o_accum == 8'h00) && $stable(o_carry); endproperty
  a_and_lit: assert property (p_and_lit) else $error("and literal result wrong");
  property p_add_lit; fast && i_op == bal_pkg::add_literal_op |=> {o_carry, o_accum} ==
    $past({1'b0, o_accum} + {1'b0, i_literal}) && o_nibble_overflow_bit ==
    $past(o_accum[3:0] + i_literal[3:0] > 5'h0F); endproperty
  a_add_lit: assert property (p_add_lit) else $error("add literal sum or flags wrong");
  // Routing by the destination select.
  property p_to_file; fop && i_dest_sel |=> o_file_we && o_file_addr == $past(i_file_addr) && $stable(o_accum);
  endproperty
  a_to_file: assert property (p_to_file) else $error("file destination not written");
  property p_to_acc; fop && !i_dest_sel |=> !o_file_we; endproperty
  a_to_acc: assert property (p_to_acc) else $error("accumulator destination wrote file");
  // Shift, bit clear and pointer add.
  property p_shift; fast && i_op == bal_pkg::arith_shift_right_op |=> o_carry == $past(i_file_rdata[0])
    && (!o_file_we || o_file_wdata == $past({i_file_rdata[7], i_file_rdata[7:1]})); endproperty
  a_shift: assert property (p_shift) else $error("shift result or carry wrong");
  property p_bclr; fast && i_op == bal_pkg::bit_clear_op |=> o_file_we && $stable(o_zero) &&
    o_file_wdata == $past(i_file_rdata & ~(8'h01 << i_bit_sel)); endproperty
  a_bclr: assert property (p_bclr) else $error("bit clear result wrong");
  property p_ptr; fast && i_op == bal_pkg::pointer_add_literal_op |=>
    $stable({o_carry, o_zero, o_nibble_overflow_bit}) && !o_file_we; endproperty
  a_ptr: assert property (p_ptr) else $error("pointer add touched flags or file");

  // Main scenarios reached.
  c_slow: cover property (take && i_indirect_slow);
  c_write: cover property (o_file_we && o_done);
  c_adc: cover property (fast && i_op == bal_pkg::add_register_with_carry_op);
endmodule

// file: bench/bal_mem_model.sv
// Data memory partner that answers file reads and takes file writes.
`timescale 1ns/1ns
module bal_mem_model
(
  // Clock.
  input  wire logic       i_core_clk,
  // Read port, answered in the same cycle.
  input  wire logic [6:0] i_rd_addr,
  output logic [7:0]      o_rd_data,
  // Write port from the datapath.
  input  wire logic       i_we,
  input  wire logic [6:0] i_wr_addr,
  input  wire logic [7:0] i_wr_data
);
  logic [7:0] mem [128];
  // Each location starts out holding its own address.
  initial
  begin
    foreach (mem[i]) mem[i] = 8'(i);
  end
  // Read data follows the address with no delay.
  assign o_rd_data = mem[i_rd_addr];
  // A write lands on the edge at which the pulse is seen.
  always @(posedge i_core_clk)
  begin
    if (i_we) mem[i_wr_addr] <= i_wr_data;
  end
endmodule

// file: bench/bal_core_tb_top.sv
// Self-checking bench for the byte datapath with a data memory partner.
`timescale 1ns/1ns
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin mismatches++; \
  $display("CHECK FAILED at %0t: got %0h want %0h", $time, g, e); end end
module bal_core_tb_top;
  logic             i_core_clk, i_rst, i_op_valid, i_dest_sel, i_ptr_sel, i_indirect_slow;
  bal_pkg::bal_op_e i_op;
  logic [7:0]       i_literal, i_file_rdata, o_accum, o_file_wdata, exp_val;
  logic [6:0]       i_file_addr, o_file_addr;
  logic [2:0]       i_bit_sel;
  logic             o_ready, o_done, o_carry, o_nibble_overflow_bit, o_zero, o_file_we;
  logic [15:0]      o_indirect_pointer0, o_indirect_pointer1;
  int               mismatches, check_count;

  bal_core uut (.i_core_clk, .i_rst, .i_op_valid, .i_op, .i_literal, .i_file_addr, .i_file_rdata,
    .i_dest_sel, .i_bit_sel, .i_ptr_sel, .i_indirect_slow, .o_ready, .o_done, .o_accum, .o_carry,
    .o_nibble_overflow_bit, .o_zero, .o_file_we, .o_file_addr, .o_file_wdata, .o_indirect_pointer0,
    .o_indirect_pointer1);
  bal_mem_model u_mem (.i_core_clk, .i_rd_addr(i_file_addr), .o_rd_data(i_file_rdata),
    .i_we(o_file_we), .i_wr_addr(o_file_addr), .i_wr_data(o_file_wdata));

  // Free-running core clock.
  initial
  begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Presents one request at a falling edge and checks completion where it is due.
  task automatic run(input bal_pkg::bal_op_e op, input logic [7:0] lit, input logic [6:0] adr,
                     input logic dst, input logic [2:0] bs, input logic ps, input logic sl);
    i_op_valid = 1'b1;
    i_op = op;
    i_literal = lit;
    i_file_addr = adr;
    i_dest_sel = dst;
    i_bit_sel = bs;
    i_ptr_sel = ps;
    i_indirect_slow = sl;
    @(negedge i_core_clk);
    if (sl)
    begin
      `CHK(o_ready, 1'b0)
      @(negedge i_core_clk);
    end
    `CHK(o_done, 1'b1)
  endtask

  // Idles one cycle so a file write lands before it is read again.
  task automatic gap();
    i_op_valid = 1'b0;
    @(negedge i_core_clk);
    `CHK(o_done, 1'b0)
  endtask

  // Main sequence of operations with expected results.
  initial
  begin
    i_rst = 1'b1;
    i_op_valid = 1'b0;
    i_op = bal_pkg::and_literal_op;
    {i_literal, i_file_addr, i_dest_sel, i_bit_sel, i_ptr_sel, i_indirect_slow} = '0;
    repeat (4) @(negedge i_core_clk);
    i_rst = 1'b0;
    `CHK({o_ready, o_done, o_accum, o_carry, o_nibble_overflow_bit, o_zero}, 13'h1000)
    `CHK({o_indirect_pointer0, o_indirect_pointer1, o_file_we}, 33'h0)
    run(bal_pkg::and_literal_op, 8'hFF, 7'h00, 1'b0, 3'h0, 1'b0, 1'b0);
    `CHK({o_accum, o_zero}, 9'h001)
    run(bal_pkg::add_literal_op, 8'h0F, 7'h00, 1'b0, 3'h0, 1'b0, 1'b0);
    `CHK({o_accum, o_carry, o_nibble_overflow_bit, o_zero}, 11'h078)
    run(bal_pkg::add_literal_op, 8'h01, 7'h00, 1'b0, 3'h0, 1'b0, 1'b0);
    `CHK({o_accum, o_carry, o_nibble_overflow_bit, o_zero}, 11'h082)
    run(bal_pkg::add_literal_op, 8'hF0, 7'h00, 1'b0, 3'h0, 1'b0, 1'b1);
    `CHK({o_accum, o_carry, o_nibble_overflow_bit, o_zero}, 11'h005)
    run(bal_pkg::add_register_with_carry_op, 8'h00, 7'h05, 1'b0, 3'h0, 1'b0, 1'b0);
    `CHK({o_file_we, o_accum, o_carry, o_nibble_overflow_bit, o_zero}, 12'h030)
    run(bal_pkg::add_register_op, 8'h00, 7'h7F, 1'b1, 3'h0, 1'b0, 1'b0);
    `CHK({o_file_we, o_file_addr, o_file_wdata}, 16'hFF85)
    `CHK({o_accum, o_carry, o_nibble_overflow_bit, o_zero}, 11'h032)
    gap();
    run(bal_pkg::and_register_op, 8'h00, 7'h7F, 1'b0, 3'h0, 1'b0, 1'b0);
    `CHK({o_file_we, o_accum, o_carry, o_nibble_overflow_bit, o_zero}, 12'h022)
    run(bal_pkg::arith_shift_right_op, 8'h00, 7'h7F, 1'b1, 3'h0, 1'b0, 1'b0);
    `CHK({o_file_we, o_file_wdata, o_carry, o_nibble_overflow_bit, o_zero}, 12'hE16)
    gap();
    exp_val = 8'hC2;
    for (int b = 0; b < 8; b++)
    begin
      run(bal_pkg::bit_clear_op, 8'h00, 7'h7F, 1'b0, 3'(b), 1'b0, 1'b0);
      exp_val[b] = 1'b0;
      `CHK({o_file_we, o_file_wdata, o_carry, o_nibble_overflow_bit, o_zero}, {1'b1, exp_val, 3'b110})
      gap();
    end
    run(bal_pkg::pointer_add_literal_op, 8'h3F, 7'h00, 1'b0, 3'h0, 1'b0, 1'b0);
    `CHK(o_indirect_pointer0, 16'hFFFF)
    run(bal_pkg::pointer_add_literal_op, 8'h01, 7'h00, 1'b0, 3'h0, 1'b0, 1'b0);
    `CHK(o_indirect_pointer0, 16'h0000)
    run(bal_pkg::pointer_add_literal_op, 8'h1F, 7'h00, 1'b0, 3'h0, 1'b0, 1'b0);
    `CHK(o_indirect_pointer0, 16'h001F)
    run(bal_pkg::pointer_add_literal_op, 8'h20, 7'h00, 1'b0, 3'h0, 1'b1, 1'b1);
    `CHK({o_indirect_pointer1, o_indirect_pointer0, o_carry, o_zero}, 34'h3FF80007E)
    gap();
    // A reset in mid-run must clear the pointers and flags that the operations above left set.
    i_rst = 1'b1;
    @(negedge i_core_clk);
    i_rst = 1'b0;
    `CHK({o_ready, o_done, o_accum, o_carry, o_nibble_overflow_bit, o_zero}, 13'h1000)
    `CHK({o_indirect_pointer0, o_indirect_pointer1, o_file_we}, 33'h0)
    run(bal_pkg::arith_shift_right_op, 8'h00, 7'h01, 1'b0, 3'h0, 1'b0, 1'b0);
    `CHK({o_file_we, o_accum, o_carry, o_nibble_overflow_bit, o_zero}, 12'h005)
    gap();
    stop_test();
  end

  // Cuts a hung run short long after the sequence should have ended.
  initial
  begin
    #20000;
    mismatches++;
    stop_test();
  end
endmodule

bind bal_core bal_core_monitor u_mon (.i_core_clk, .i_rst, .i_op_valid, .i_op, .i_literal, .i_file_addr,
  .i_file_rdata, .i_dest_sel, .i_bit_sel, .i_indirect_slow, .o_ready, .o_done, .o_accum, .o_carry,
  .o_nibble_overflow_bit, .o_zero, .o_file_we, .o_file_addr, .o_file_wdata);
